// ---- src/bia_pend.v ----
// Sticky pending flags, one per source register of a block.
// Assumes set pulses and clear strobes come from logic on clk_i.
module bia_pend #(
  parameter N = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [N-1:0] set_i,
  input wire [N-1:0] clr_i,
  output reg [N-1:0] pend_o
);

  // A set arriving with its own clear is kept
  always @(posedge clk_i) begin
    if (rst_i) begin
      pend_o <= {N{1'b0}};
    end else begin
      pend_o <= (pend_o & ~clr_i) | set_i;
    end
  end

endmodule

// ---- src/bia_regs.vh ----
// Register map, field positions and widths of the block interrupt aggregator.
// Assumes word-addressed registers on a 32-bit Wishbone bus (byte address = 4 x index).
`ifndef BIA_REGS_VH
`define BIA_REGS_VH

// Bus geometry
`define BIA_ADR_W 16
`define BIA_DAT_W 32
`define BIA_IDX_W 14
`define BIA_REG_W 8
`define BIA_ADR_LSB 2

// Register indices (byte address is four times the index)
`define BIA_IDX_STATUS 14'h0B00
`define BIA_IDX_ENABLE 14'h0B01
`define BIA_IDX_FRAMER_SRC 14'h0B04
`define BIA_IDX_SLIP_SRC 14'h0B08
`define BIA_IDX_LOOP_SRC 14'h0B0A
`define BIA_IDX_ALARM_SRC0 14'h0B02
`define BIA_IDX_ALARM_SRC1 14'h0B0E
`define BIA_IDX_ALARM_SRC2 14'h0B40
`define BIA_IDX_DL_SRC0 14'h0B06
`define BIA_IDX_DL_SRC1 14'h0B16
`define BIA_IDX_DL_SRC2 14'h0B26
`define BIA_IDX_DL_SRC3 14'h0B10
`define BIA_IDX_DL_SRC4 14'h0B18
`define BIA_IDX_DL_SRC5 14'h0B28

// Field positions shared by status and enable registers
`define BIA_BIT_FRAMER 0
`define BIA_BIT_ALARM 1
`define BIA_BIT_SLIP 2
`define BIA_BIT_DL 3
`define BIA_BIT_TICK 4
`define BIA_BIT_CLKLOSS 5
`define BIA_BIT_LOOP 6
`define BIA_FIELD_W 7

// Reset values
`define BIA_ENABLE_RST 7'h00
`define BIA_STATUS_RST 7'h00

// Source register counts per block
`define BIA_ALARM_SRCS 3
`define BIA_DL_SRCS 6

`endif

// ---- src/bia_top.v ----
// Block interrupt aggregator: block status, block enable and the interrupt pin.
// Assumes all request pulses and source register values come from logic on clk_i;
// source blocks apply their own source-level enables before pulsing a request.
`include "bia_regs.vh"

// Notes on behaviour
// - Read-only block status register at index 0x0B00, all fields reset to zero.
// - Status bit 2 shows an unserviced slip buffer request.
// - Reading the slip buffer source register 0x0B08 clears status bit 2.
// - Status bit 1 shows an unserviced alarm and error request.
// - Reading the alarm source register that raised it clears status bit 1.
// - Status bit 0 shows an unserviced framer request.
// - Reading the framer source register 0x0B04 clears status bit 0.
// - Enable bit 6 gates loop code interrupts at block level, reset 0.
// - Enable bit 5 is the source enable of recovered clock loss.
// - Enable bit 4 is the source enable of the one-second tick.
// - Enable bit 3 gates data-link interrupts at block level, reset 0.
// - Pin needs both block enable and source enable of a request.
// - Enable bits 2,1,0 gate slip, alarm and framer interrupts at block level.
// - Status bits 6..3 show loop code, clock loss, tick and data-link requests.
// - Data-link and loop code bits clear on read of the raising source register.
module bia_top (
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`BIA_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [`BIA_DAT_W-1:0] wb_dat_i,
  output wire wb_ack_o,
  output reg [`BIA_DAT_W-1:0] wb_dat_o,
  // Request pulses from the functional blocks
  input wire framer_req_i,
  input wire [`BIA_ALARM_SRCS-1:0] alarm_req_i,
  input wire slip_req_i,
  input wire [`BIA_DL_SRCS-1:0] data_link_req_i,
  input wire second_tick_i,
  input wire recovered_clock_loss_i,
  input wire loop_code_req_i,
  // Current values of the source-level status registers
  input wire [`BIA_REG_W-1:0] framer_src_dat_i,
  input wire [`BIA_ALARM_SRCS*`BIA_REG_W-1:0] alarm_src_dat_i,
  input wire [`BIA_REG_W-1:0] slip_src_dat_i,
  input wire [`BIA_DL_SRCS*`BIA_REG_W-1:0] data_link_src_dat_i,
  input wire [`BIA_REG_W-1:0] loop_code_src_dat_i,
  // Read strobes back to the source blocks
  output reg framer_src_rd_o,
  output reg [`BIA_ALARM_SRCS-1:0] alarm_src_rd_o,
  output reg slip_src_rd_o,
  output reg [`BIA_DL_SRCS-1:0] data_link_src_rd_o,
  output reg loop_code_src_rd_o,
  // Interrupt pin, active high
  output reg irq_o
);

  wire take;
  wire [`BIA_IDX_W-1:0] idx;
  wire take_rd;
  wire take_wr;

  reg [`BIA_FIELD_W-1:0] block_irq_enable;
  wire [`BIA_FIELD_W-1:0] block_irq_status;

  wire hit_status;
  wire hit_enable;
  wire hit_framer;
  wire hit_slip;
  wire hit_loop;
  wire [`BIA_ALARM_SRCS-1:0] hit_alarm;
  wire [`BIA_DL_SRCS-1:0] hit_dl;

  wire framer_block_pending;
  wire [`BIA_ALARM_SRCS-1:0] alarm_pend;
  wire slip_pend;
  wire [`BIA_DL_SRCS-1:0] dl_pend;
  wire loop_code_pending;
  wire second_tick_pending;
  wire recovered_clock_loss_pending;

  wire loop_code_block_en;
  wire recovered_clock_loss_en;
  wire second_tick_en;
  wire data_link_block_en;
  wire elastic_store_block_en;
  wire defect_block_en;
  wire framer_block_en;

  reg [`BIA_DAT_W-1:0] next_rdata;
  reg next_irq;

  bia_wb_port u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o),
    .take_o(take),
    .idx_o(idx)
  );

  assign take_rd = take & ~wb_we_i;
  assign take_wr = take & wb_we_i;

  // Address decode
  assign hit_status = (idx == `BIA_IDX_STATUS);
  assign hit_enable = (idx == `BIA_IDX_ENABLE);
  assign hit_framer = (idx == `BIA_IDX_FRAMER_SRC);
  assign hit_slip = (idx == `BIA_IDX_SLIP_SRC);
  assign hit_loop = (idx == `BIA_IDX_LOOP_SRC);
  assign hit_alarm[0] = (idx == `BIA_IDX_ALARM_SRC0);
  assign hit_alarm[1] = (idx == `BIA_IDX_ALARM_SRC1);
  assign hit_alarm[2] = (idx == `BIA_IDX_ALARM_SRC2);
  assign hit_dl[0] = (idx == `BIA_IDX_DL_SRC0);
  assign hit_dl[1] = (idx == `BIA_IDX_DL_SRC1);
  assign hit_dl[2] = (idx == `BIA_IDX_DL_SRC2);
  assign hit_dl[3] = (idx == `BIA_IDX_DL_SRC3);
  assign hit_dl[4] = (idx == `BIA_IDX_DL_SRC4);
  assign hit_dl[5] = (idx == `BIA_IDX_DL_SRC5);

  // Enable register fields
  assign loop_code_block_en = block_irq_enable[`BIA_BIT_LOOP];
  assign recovered_clock_loss_en = block_irq_enable[`BIA_BIT_CLKLOSS];
  assign second_tick_en = block_irq_enable[`BIA_BIT_TICK];
  assign data_link_block_en = block_irq_enable[`BIA_BIT_DL];
  assign elastic_store_block_en = block_irq_enable[`BIA_BIT_SLIP];
  assign defect_block_en = block_irq_enable[`BIA_BIT_ALARM];
  assign framer_block_en = block_irq_enable[`BIA_BIT_FRAMER];

  // Enable register: only byte lane 0 carries fields, bit 7 is not stored
  always @(posedge clk_i) begin
    if (rst_i) begin
      block_irq_enable <= `BIA_ENABLE_RST;
    end else if (take_wr && hit_enable && wb_sel_i[0]) begin
      block_irq_enable <= wb_dat_i[`BIA_FIELD_W-1:0];
    end
  end

  // Per-block pending flags, cleared by a read of the raising source register
  bia_pend #(
    .N(1)
  ) u_framer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(framer_req_i),
    .clr_i(take_rd & hit_framer),
    .pend_o(framer_block_pending)
  );

  bia_pend #(
    .N(`BIA_ALARM_SRCS)
  ) u_alarm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(alarm_req_i),
    .clr_i({`BIA_ALARM_SRCS{take_rd}} & hit_alarm),
    .pend_o(alarm_pend)
  );

  bia_pend #(
    .N(1)
  ) u_slip (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(slip_req_i),
    .clr_i(take_rd & hit_slip),
    .pend_o(slip_pend)
  );

  bia_pend #(
    .N(`BIA_DL_SRCS)
  ) u_dl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(data_link_req_i),
    .clr_i({`BIA_DL_SRCS{take_rd}} & hit_dl),
    .pend_o(dl_pend)
  );

  bia_pend #(
    .N(1)
  ) u_loop (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(loop_code_req_i),
    .clr_i(take_rd & hit_loop),
    .pend_o(loop_code_pending)
  );

  // Tick and clock loss have no register of their own: a status read services them
  bia_pend #(
    .N(1)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(second_tick_i & second_tick_en),
    .clr_i(take_rd & hit_status),
    .pend_o(second_tick_pending)
  );

  bia_pend #(
    .N(1)
  ) u_clkloss (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(recovered_clock_loss_i & recovered_clock_loss_en),
    .clr_i(take_rd & hit_status),
    .pend_o(recovered_clock_loss_pending)
  );

  // Block status composition
  assign block_irq_status[`BIA_BIT_FRAMER] = framer_block_pending;
  assign block_irq_status[`BIA_BIT_ALARM] = |alarm_pend;
  assign block_irq_status[`BIA_BIT_SLIP] = slip_pend;
  assign block_irq_status[`BIA_BIT_DL] = |dl_pend;
  assign block_irq_status[`BIA_BIT_TICK] = second_tick_pending;
  assign block_irq_status[`BIA_BIT_CLKLOSS] = recovered_clock_loss_pending;
  assign block_irq_status[`BIA_BIT_LOOP] = loop_code_pending;

  // Read data; unmapped addresses read zero
  always @* begin
    next_rdata = {`BIA_DAT_W{1'b0}};
    if (hit_status) begin
      next_rdata[`BIA_FIELD_W-1:0] = block_irq_status;
    end else if (hit_enable) begin
      next_rdata[`BIA_FIELD_W-1:0] = block_irq_enable;
    end else if (hit_framer) begin
      next_rdata[`BIA_REG_W-1:0] = framer_src_dat_i;
    end else if (hit_slip) begin
      next_rdata[`BIA_REG_W-1:0] = slip_src_dat_i;
    end else if (hit_loop) begin
      next_rdata[`BIA_REG_W-1:0] = loop_code_src_dat_i;
    end else if (hit_alarm[0]) begin
      next_rdata[`BIA_REG_W-1:0] = alarm_src_dat_i[`BIA_REG_W-1:0];
    end else if (hit_alarm[1]) begin
      next_rdata[`BIA_REG_W-1:0] = alarm_src_dat_i[2*`BIA_REG_W-1:`BIA_REG_W];
    end else if (hit_alarm[2]) begin
      next_rdata[`BIA_REG_W-1:0] = alarm_src_dat_i[3*`BIA_REG_W-1:2*`BIA_REG_W];
    end else if (hit_dl[0]) begin
      next_rdata[`BIA_REG_W-1:0] = data_link_src_dat_i[`BIA_REG_W-1:0];
    end else if (hit_dl[1]) begin
      next_rdata[`BIA_REG_W-1:0] = data_link_src_dat_i[2*`BIA_REG_W-1:`BIA_REG_W];
    end else if (hit_dl[2]) begin
      next_rdata[`BIA_REG_W-1:0] = data_link_src_dat_i[3*`BIA_REG_W-1:2*`BIA_REG_W];
    end else if (hit_dl[3]) begin
      next_rdata[`BIA_REG_W-1:0] = data_link_src_dat_i[4*`BIA_REG_W-1:3*`BIA_REG_W];
    end else if (hit_dl[4]) begin
      next_rdata[`BIA_REG_W-1:0] = data_link_src_dat_i[5*`BIA_REG_W-1:4*`BIA_REG_W];
    end else if (hit_dl[5]) begin
      next_rdata[`BIA_REG_W-1:0] = data_link_src_dat_i[6*`BIA_REG_W-1:5*`BIA_REG_W];
    end
  end

  // Read data is captured with the ack and held until the next read
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= {`BIA_DAT_W{1'b0}};
    end else if (take_rd) begin
      wb_dat_o <= next_rdata;
    end
  end

  // Read strobes to source blocks, high in the ack cycle of the read
  always @(posedge clk_i) begin
    if (rst_i) begin
      framer_src_rd_o <= 1'b0;
      alarm_src_rd_o <= {`BIA_ALARM_SRCS{1'b0}};
      slip_src_rd_o <= 1'b0;
      data_link_src_rd_o <= {`BIA_DL_SRCS{1'b0}};
      loop_code_src_rd_o <= 1'b0;
    end else begin
      framer_src_rd_o <= take_rd & hit_framer;
      alarm_src_rd_o <= {`BIA_ALARM_SRCS{take_rd}} & hit_alarm;
      slip_src_rd_o <= take_rd & hit_slip;
      data_link_src_rd_o <= {`BIA_DL_SRCS{take_rd}} & hit_dl;
      loop_code_src_rd_o <= take_rd & hit_loop;
    end
  end

  // Interrupt pin: any pending block whose enable is set
  always @* begin
    next_irq = 1'b0;
    if (framer_block_pending && framer_block_en) begin
      next_irq = 1'b1;
    end
    if ((|alarm_pend) && defect_block_en) begin
      next_irq = 1'b1;
    end
    if (slip_pend && elastic_store_block_en) begin
      next_irq = 1'b1;
    end
    if ((|dl_pend) && data_link_block_en) begin
      next_irq = 1'b1;
    end
    if (loop_code_pending && loop_code_block_en) begin
      next_irq = 1'b1;
    end
    if (second_tick_pending && second_tick_en) begin
      next_irq = 1'b1;
    end
    if (recovered_clock_loss_pending && recovered_clock_loss_en) begin
      next_irq = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

endmodule

// ---- src/bia_wb_port.v ----
// Classic Wishbone slave handshake: one registered ack per request.
// Assumes a single master that holds the request until it samples ack.
`include "bia_regs.vh"

module bia_wb_port (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [`BIA_ADR_W-1:0] wb_adr_i,
  output reg wb_ack_o,
  output wire take_o,
  output wire [`BIA_IDX_W-1:0] idx_o
);

  // Request is taken on the edge that raises ack
  assign take_o = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx_o = wb_adr_i[`BIA_ADR_W-1:`BIA_ADR_LSB];

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= take_o;
    end
  end

endmodule

// ---- verif/bia_checker.sv ----
// Checker of the aggregator bus handshake and source read strobes.
// Assumes it is bound to bia_top and sees only its ports.
`include "bia_regs.vh"
module bia_checker (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [`BIA_ADR_W-1:0] wb_adr_i,
  input logic wb_ack_o,
  input logic [`BIA_DAT_W-1:0] wb_dat_o,
  input logic framer_src_rd_o,
  input logic [`BIA_ALARM_SRCS-1:0] alarm_src_rd_o,
  input logic slip_src_rd_o,
  input logic [`BIA_DL_SRCS-1:0] data_link_src_rd_o,
  input logic loop_code_src_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [13:0] idx);
    s_take ##0 (!wb_we_i && wb_adr_i[15:2] == idx);
  endsequence
  a_ack_after_take: assert property (s_take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_status_upper_zero: assert property (s_rd(14'h0B00) |=> wb_dat_o[31:7] == 25'h0)
    else $error("status upper bits not zero");
  a_slip_read_strobe: assert property (s_rd(14'h0B08) |=> slip_src_rd_o && wb_ack_o)
    else $error("slip source read strobe missing");
  a_framer_read_strobe: assert property (s_rd(14'h0B04) |=> framer_src_rd_o)
    else $error("framer source read strobe missing");
  a_loop_read_strobe: assert property (s_rd(14'h0B0A) |=> loop_code_src_rd_o)
    else $error("loop code read strobe missing");
  a_alarm_strobe_one: assert property (alarm_src_rd_o != 3'h0 |-> wb_ack_o && $onehot(alarm_src_rd_o))
    else $error("alarm read strobe not single");
  a_dl_strobe_one: assert property (data_link_src_rd_o != 6'h00 |-> wb_ack_o && $onehot(data_link_src_rd_o))
    else $error("data link read strobe not single");
endmodule
bind bia_top bia_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .framer_src_rd_o(framer_src_rd_o), .alarm_src_rd_o(alarm_src_rd_o),
  .slip_src_rd_o(slip_src_rd_o), .data_link_src_rd_o(data_link_src_rd_o),
  .loop_code_src_rd_o(loop_code_src_rd_o));

// ---- verif/bia_src_model.sv ----
// Model of the functional blocks: request pulses and source register values.
// Assumes sources apply their own source-level enables before pulsing.
module bia_src_model (
  input logic clk_i,
  output logic [13:0] req_o,
  output logic [111:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_o = 14'h0000;
    for (int k = 0; k < 14; k++) dat_o[k*8+:8] = 8'hA0 + k[7:0];
  end
  // One request pulse of one cycle per masked source
  task pulse(input logic [13:0] m);
    @(posedge clk_i);
    req_o <= m;
    @(posedge clk_i);
    req_o <= 14'h0000;
  endtask
endmodule

// ---- verif/tb_top.sv ----
// Testbench of the block interrupt aggregator over classic Wishbone.
// Assumes byte address is four times the register index.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0, rd;
  wire wb_ack_o, irq_o;
  wire [31:0] wb_dat_o;
  wire [13:0] req;
  wire [111:0] sd;
  int err_count = 0, n_checks = 0, o;
  localparam logic [15:0] SA [14] = '{16'h2C10, 16'h2C08, 16'h2C38, 16'h2D00, 16'h2C20,
    16'h2C18, 16'h2C58, 16'h2C98, 16'h2C40, 16'h2C60, 16'h2CA0, 16'h0, 16'h0, 16'h2C28};
  localparam int SB [14] = '{0, 1, 1, 1, 2, 3, 3, 3, 3, 3, 3, 4, 5, 6};
  localparam logic [15:0] STA = 16'h2C00, ENA = 16'h2C04;
  always #4 clk_i = ~clk_i;
  bia_src_model SRC (.clk_i(clk_i), .req_o(req), .dat_o(sd));
  bia_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .framer_req_i(req[0]), .alarm_req_i(req[3:1]), .slip_req_i(req[4]),
    .data_link_req_i(req[10:5]), .second_tick_i(req[11]), .recovered_clock_loss_i(req[12]),
    .loop_code_req_i(req[13]), .framer_src_dat_i(sd[7:0]), .alarm_src_dat_i(sd[31:8]),
    .slip_src_dat_i(sd[39:32]), .data_link_src_dat_i(sd[87:40]),
    .loop_code_src_dat_i(sd[111:104]), .framer_src_rd_o(), .alarm_src_rd_o(),
    .slip_src_rd_o(), .data_link_src_rd_o(), .loop_code_src_rd_o(), .irq_o(irq_o));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wb_cycle(input logic [15:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wb_rd(input logic [15:0] a);
    wb_cycle(a, 1'b0, 32'h0, 4'hF);
  endtask
  task wb_wr(input logic [15:0] a, input logic [31:0] d);
    wb_cycle(a, 1'b1, d, 4'hF);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_rd(STA);
    chk(rd, 32'h0);
    wb_rd(ENA);
    chk(rd, 32'h0);
    chk(irq_o, 32'h0);
    wb_wr(STA, 32'hFF);
    wb_rd(STA);
    chk(rd, 32'h0);
    wb_rd(16'h3000);
    chk(rd, 32'h0);
    wb_wr(ENA, 32'h7F);
    wb_rd(ENA);
    chk(rd, 32'h7F);
    wb_cycle(ENA, 1'b1, 32'h0, 4'hE);
    wb_rd(ENA);
    chk(rd, 32'h7F);
    wb_wr(ENA, 32'h0);
    $display("register test done");
    for (int k = 0; k < 14; k++) if (SB[k] != 4 && SB[k] != 5) begin
      SRC.pulse(14'h1 << k);
      wb_rd(STA);
      chk(rd, 32'h1 << SB[k]);
      chk(irq_o, 32'h0);
      wb_wr(ENA, 32'h7F ^ (32'h1 << SB[k]));
      repeat (2) @(posedge clk_i);
      chk(irq_o, 32'h0);
      wb_wr(ENA, 32'h1 << SB[k]);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 32'h1);
      if (SB[k] == 1 || SB[k] == 3) begin
        o = (SB[k+1] == SB[k]) ? k + 1 : k - 1;
        wb_rd(SA[o]);
        wb_rd(STA);
        chk(rd, 32'h1 << SB[k]);
      end
      wb_rd(SA[k]);
      chk(rd, 32'hA0 + k);
      wb_rd(STA);
      chk(rd, 32'h0);
      chk(irq_o, 32'h0);
      wb_wr(ENA, 32'h0);
    end
    $display("block source test done");
    for (int k = 11; k < 13; k++) begin
      SRC.pulse(14'h1 << k);
      wb_rd(STA);
      chk(rd, 32'h0);
      wb_wr(ENA, 32'h1 << SB[k]);
      SRC.pulse(14'h1 << k);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 32'h1);
      wb_rd(STA);
      chk(rd, 32'h1 << SB[k]);
      wb_rd(STA);
      chk(rd, 32'h0);
      wb_wr(ENA, 32'h0);
    end
    $display("event enable test done");
    wb_wr(ENA, 32'h7F);
    SRC.pulse(14'h1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(irq_o, 32'h0);
    wb_rd(STA);
    chk(rd, 32'h0);
    wb_rd(ENA);
    chk(rd, 32'h0);
    $display("mid-run reset test done");
    complete_run;
  end
endmodule
